// ==== hdl/adc_pkg.sv ====
package adc_pkg;

  // ----------------------------------------
  // Clocking and timing
  // ----------------------------------------
  localparam int CORE_HZ = 40_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int OSC_DIV = CORE_HZ / OSC_HZ;
  localparam logic [5:0] OSC_LAST = 6'(OSC_DIV - 1);
  localparam int TIMEOUT_MS = 28;
  localparam int TIMEOUT_CYC = (CORE_HZ / 1000) * TIMEOUT_MS;
  localparam int LEAD_US = 8;
  localparam int LEAD_TICKS = (OSC_HZ / 1_000_000) * LEAD_US;
  localparam int CONV_TICKS_DEF = 1000;

  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  localparam logic [15:0] CFG_RESET = 16'h058B;
  localparam logic [15:0] CONV_RESET = 16'h0000;
  localparam int CFG_START_BIT = 15;
  localparam int CFG_MODE_BIT = 8;
  localparam int CFG_TEMP_BIT = 4;
  localparam int CFG_NOP_LSB = 1;
  localparam int CFG_RSVD_BIT = 0;
  localparam logic [1:0] NOP_WRITE = 2'h1;

  // ----------------------------------------
  // Result format
  // ----------------------------------------
  localparam int CODE_MAX = 2047;
  localparam int CODE_MIN = -2048;
  localparam logic [15:0] CLIP_POS = 16'h7FF0;
  localparam logic [15:0] CLIP_NEG = 16'h8000;
  localparam logic [3:0] PAD_ZERO = 4'h0;
  localparam logic [5:0] HALF_BITS = 6'h10;
  localparam logic [5:0] XFER_BITS = 6'h20;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } spi_in_t;

  typedef struct packed {
    logic data_out_ready_n;
    logic data_out_ready_n_oe;
  } spi_out_t;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

  typedef struct packed {
    spi_in_t meta;
    spi_in_t stable;
  } sync_state_t;

  typedef struct packed {
    conv_state_t state;
    logic [15:0] cfg;
    logic [15:0] conv;
    logic new_data;
    logic powered;
    logic [5:0] osc_cnt;
    logic osc_tick;
    logic [15:0] conv_cnt;
    logic sclk_q;
    logic active;
    logic [5:0] fall_cnt;
    logic [31:0] shift_out;
    logic [15:0] shift_in;
    logic [20:0] idle_cnt;
    spi_out_t pin;
  } adc_state_t;

  localparam adc_state_t ADC_RESET = '{
    state: ST_SLEEP,
    cfg: CFG_RESET,
    conv: CONV_RESET,
    new_data: 1'b0,
    powered: 1'b0,
    osc_cnt: 6'h00,
    osc_tick: 1'b0,
    conv_cnt: 16'h0000,
    sclk_q: 1'b0,
    active: 1'b0,
    fall_cnt: 6'h00,
    shift_out: 32'h0000_0000,
    shift_in: 16'h0000,
    idle_cnt: 21'h00_0000,
    pin: '{data_out_ready_n: 1'b1, data_out_ready_n_oe: 1'b0}
  };

endpackage : adc_pkg

// ==== hdl/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
  import adc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input adc_pkg::spi_in_t pins,
  output adc_pkg::spi_in_t pins_sync
);

  sync_state_t st_reg;
  sync_state_t st_next;

  // ----------------------------------------
  // Two stage synchroniser
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.meta = pins;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      st_reg <= '{meta: '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0}, stable: '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pins_sync = st_reg.stable;

endmodule : pin_sync

// ==== hdl/adc_ctrl.sv ====
`timescale 1ns/1ps
// Operation
// (R1) Timing from internal 1 MHz oscillator only; the clock-low timeout counts core clock cycles instead
// (R2) Temp select bit picks temperature sensor
// (R3) Temperature: 12 bits, upper word, MSB first
// (R4) 0.125 C per count, two's complement
// (R5) Reset loads defaults, starts powered down
// (R6) Mode bit one: single-shot, default
// (R7) Start bit: power up, clear, one conversion
// (R8) Start ignored while converting
// (R9) Mode zero: store result, restart immediately
// (R10) Leave continuous by mode write or reset
// (R11) Four wire or three wire with select low
// (R12) Select high: reset port, tri-state pin
// (R13) Select falls: pin shows ready state
// (R14) Result snapshot held through whole transfer
// (R15) Clock low 28 ms resets port
// (R16) Host keeps clock low when idle
// (R17) Sample data in on falling edge
// (R18) Data out changes on rising edge
// (R19) Pin low when new result available
// (R20) Unread result: pin high 8 us early
// (R21) Host reads before pin returns high
// (R22) Host holds select low per transfer
// (R23) Left-justified, clipped at 7FF0 / 8000
// (R24) Written config read back in last half
module adc_ctrl
  import adc_pkg::*;
#(
  parameter int SUM_W = 16,
  parameter int CONV_TICKS = CONV_TICKS_DEF,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input adc_pkg::spi_in_t spi_pins,
  output adc_pkg::spi_out_t spi_out,
  input wire logic signed [SUM_W-1:0] sample_value,
  input wire logic [11:0] temp_value,
  output logic afe_powered,
  output logic temp_sensor_select,
  output logic [15:0] afe_config,
  output logic result_ready
);

  import adc_pkg::*;

  adc_state_t st_reg;
  adc_state_t st_next;
  spi_in_t pins_s;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  pin_sync u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pins(spi_pins),
    .pins_sync(pins_s)
  );

  // ----------------------------------------
  // Result formatting
  // ----------------------------------------
  function automatic logic [15:0] format_result(
    input logic temp_sel,
    input logic signed [SUM_W-1:0] v,
    input logic [11:0] t
  );
    logic [15:0] r;
    r = CONV_RESET;
    // (R3) Temperature left-justified
    // (R4) Two's complement passthrough
    if (temp_sel)
    begin
      r = {t, PAD_ZERO};
    end
    // (R23) Clip at full scale
    else if (v > CODE_MAX)
    begin
      r = CLIP_POS;
    end
    else if (v < CODE_MIN)
    begin
      r = CLIP_NEG;
    end
    else
    begin
      r = {v[11:0], PAD_ZERO};
    end
    return r;
  endfunction : format_result

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic conv_done;
    logic wr;
    logic wr_start;
    logic [5:0] fall_num;
    logic [15:0] word_in;
    logic [31:0] word_out;
    rise = 1'b0;
    fall = 1'b0;
    conv_done = 1'b0;
    wr = 1'b0;
    wr_start = 1'b0;
    fall_num = 6'h00;
    word_in = 16'h0000;
    word_out = 32'h0000_0000;
    st_next = st_reg;
    st_next.sclk_q = pins_s.sclk;

    // (R1) Oscillator tick from core clock
    st_next.osc_tick = 1'b0;
    if (st_reg.osc_cnt == OSC_LAST)
    begin
      st_next.osc_cnt = 6'h00;
      st_next.osc_tick = 1'b1;
    end
    else
    begin
      st_next.osc_cnt = st_reg.osc_cnt + 6'h01;
    end

    // (R12) Deselected port held in reset
    if (pins_s.cs_n)
    begin
      st_next.active = 1'b0;
      st_next.fall_cnt = 6'h00;
      st_next.idle_cnt = 21'h00_0000;
      st_next.pin.data_out_ready_n = 1'b1;
      st_next.pin.data_out_ready_n_oe = 1'b0;
    end
    else
    begin
      // (R11) Port runs whenever select is low
      rise = pins_s.sclk & ~st_reg.sclk_q;
      fall = ~pins_s.sclk & st_reg.sclk_q;
      st_next.pin.data_out_ready_n_oe = 1'b1;
      // (R13) Idle pin shows ready state
      if (!st_reg.active)
      begin
        st_next.pin.data_out_ready_n = ~st_reg.new_data;
      end
      if (rise)
      begin
        // (R14) Snapshot result at transfer start
        word_out = st_reg.active ? st_reg.shift_out : {st_reg.conv, st_reg.cfg};
        // (R18) Shift out on rising edge
        st_next.pin.data_out_ready_n = word_out[31];
        st_next.shift_out = {word_out[30:0], 1'b0};
        if (!st_reg.active)
        begin
          st_next.active = 1'b1;
          st_next.new_data = 1'b0;
        end
      end
      if (fall && st_reg.active)
      begin
        // (R17) Sample data in on falling edge
        word_in = {st_reg.shift_in[14:0], pins_s.din};
        fall_num = st_reg.fall_cnt + 6'h01;
        st_next.shift_in = word_in;
        st_next.fall_cnt = fall_num;
        if (fall_num == HALF_BITS || fall_num == XFER_BITS)
        begin
          wr = (word_in[CFG_NOP_LSB +: 2] == NOP_WRITE);
          wr_start = wr & word_in[CFG_START_BIT];
          if (wr)
          begin
            st_next.cfg = word_in;
            st_next.cfg[CFG_START_BIT] = 1'b0;
            st_next.cfg[CFG_RSVD_BIT] = 1'b1;
          end
        end
        // (R24) Readback of config from first half
        if (fall_num == HALF_BITS)
        begin
          st_next.shift_out[31:16] = st_next.cfg;
        end
        if (fall_num == XFER_BITS)
        begin
          st_next.active = 1'b0;
          st_next.fall_cnt = 6'h00;
        end
      end
      // (R15) Clock-low timeout resets port
      if (pins_s.sclk)
      begin
        st_next.idle_cnt = 21'h00_0000;
      end
      else if (st_reg.idle_cnt == 21'(TIMEOUT_CYCLES - 1))
      begin
        st_next.active = 1'b0;
        st_next.fall_cnt = 6'h00;
      end
      else
      begin
        st_next.idle_cnt = st_reg.idle_cnt + 21'h00_0001;
      end
    end

    // Conversion sequencing
    unique case (st_reg.state)
      ST_SLEEP:
      begin
        st_next.powered = 1'b0;
      end
      ST_CONVERT:
      begin
        st_next.powered = 1'b1;
        // (R20) Unread result withdrawn early
        if (!st_reg.cfg[CFG_MODE_BIT] && st_reg.conv_cnt >= 16'(CONV_TICKS - LEAD_TICKS))
        begin
          st_next.new_data = 1'b0;
        end
        if (st_reg.osc_tick)
        begin
          if (st_reg.conv_cnt == 16'(CONV_TICKS - 1))
          begin
            conv_done = 1'b1;
            st_next.conv_cnt = 16'h0000;
          end
          else
          begin
            st_next.conv_cnt = st_reg.conv_cnt + 16'h0001;
          end
        end
        if (conv_done)
        begin
          // (R2) Source picked by temp select
          // (R9) Store result, set ready
          st_next.conv = format_result(st_reg.cfg[CFG_TEMP_BIT], sample_value, temp_value);
          // (R19) New result drives pin low
          st_next.new_data = 1'b1;
          // (R7) Power down after one conversion
          // (R10) Mode one ends continuous run
          if (st_reg.cfg[CFG_MODE_BIT])
          begin
            st_next.state = ST_SLEEP;
            st_next.powered = 1'b0;
          end
        end
      end
      default:
      begin
        st_next.state = ST_SLEEP;
      end
    endcase

    // (R6) Single-shot waits for start write
    // (R8) Start ignored unless asleep
    if (st_next.state == ST_SLEEP && (wr_start || !st_next.cfg[CFG_MODE_BIT]))
    begin
      st_next.state = ST_CONVERT;
      st_next.powered = 1'b1;
      st_next.conv_cnt = 16'h0000;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    // (R5) Reset restores defaults, asleep
    if (!rstn)
    begin
      st_reg <= ADC_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign spi_out = st_reg.pin;
  assign afe_powered = st_reg.powered;
  assign temp_sensor_select = st_reg.cfg[CFG_TEMP_BIT];
  assign afe_config = st_reg.cfg;
  assign result_ready = st_reg.new_data;

endmodule : adc_ctrl

// ==== sim/adc_ctrl_chk.sv ====
`timescale 1ns/1ps
module adc_ctrl_chk
  import adc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input adc_pkg::spi_in_t spi_pins,
  input adc_pkg::spi_out_t spi_out,
  input wire logic afe_powered,
  input wire logic temp_sensor_select,
  input wire logic [15:0] afe_config,
  input wire logic result_ready
);
  // ----
  // Port checks
  // ----
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  chk_reset_vals: assert property ($rose(rstn) |-> afe_config == CFG_RESET && !afe_powered && !result_ready)
    else $error("reset values wrong");
  chk_temp_bit: assert property (temp_sensor_select == afe_config[CFG_TEMP_BIT])
    else $error("temp select mismatch");
  chk_temp_write: assert property ($changed(temp_sensor_select) |-> !$past(spi_pins.cs_n, 3))
    else $error("temp select changed outside a transfer");
  chk_start_clear: assert property (!afe_config[CFG_START_BIT])
    else $error("start bit stuck");
  chk_cont_power: assert property (!afe_config[CFG_MODE_BIT] [*3] |-> afe_powered)
    else $error("continuous mode idle");
  chk_single_down: assert property ($fell(afe_powered) && afe_config[CFG_MODE_BIT] |-> ##[0:1] result_ready)
    else $error("powered down without result");
  chk_sel_drive: assert property ($fell(spi_pins.cs_n) |-> ##[1:5] spi_out.data_out_ready_n_oe)
    else $error("pin not driven");
  chk_desel_float: assert property ($rose(spi_pins.cs_n) |-> ##[1:5] !spi_out.data_out_ready_n_oe)
    else $error("pin not released");
  chk_tristate: assert property (spi_pins.cs_n [*5] |-> !spi_out.data_out_ready_n_oe)
    else $error("pin driven while deselected");
  chk_ready_level: assert property ($rose(spi_out.data_out_ready_n_oe) |->
    spi_out.data_out_ready_n != $past(result_ready))
    else $error("ready level wrong");
endmodule : adc_ctrl_chk

bind adc_ctrl adc_ctrl_chk chk (.core_clk(core_clk), .rstn(rstn), .spi_pins(spi_pins), .spi_out(spi_out),
  .afe_powered(afe_powered), .temp_sensor_select(temp_sensor_select), .afe_config(afe_config),
  .result_ready(result_ready));

// ==== sim/spi_host.sv ====
`timescale 1ns/1ps
module spi_host
  import adc_pkg::*;
(
  output adc_pkg::spi_in_t pins,
  input adc_pkg::spi_out_t pin_out
);
  // ----
  // Host side of the link
  // ----
  logic line;
  logic rdy;
  assign line = pin_out.data_out_ready_n_oe ? pin_out.data_out_ready_n : !pin_out.data_out_ready_n;
  initial pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
  task automatic xfer(input int n, input logic [31:0] wr, input bit hold, output logic [31:0] rd);
    rd = 32'h0000_0000;
    pins.cs_n <= 1'b0;
    #200;
    rdy = line;
    for (int i = 0; i < n; i++)
    begin
      pins.sclk <= 1'b1;
      pins.din <= wr[31 - i];
      #100;
      pins.sclk <= 1'b0;
      #100;
      rd = {rd[30:0], line};
    end
    pins.cs_n <= !hold;
    #200;
  endtask : xfer
endmodule : spi_host

// ==== sim/adc_ctrl_test.sv ====
`timescale 1ns/1ps
module adc_ctrl_test;
  import adc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  adc_pkg::spi_in_t spi_pins;
  adc_pkg::spi_out_t spi_out;
  logic signed [15:0] sample_value = 16'h0000;
  logic [11:0] temp_value = 12'hF38;
  logic afe_powered;
  logic temp_sensor_select;
  logic [15:0] afe_config;
  logic result_ready;
  logic [31:0] rd;
  int errors = 0;
  int total_checks = 0;
  // ----
  // Bench
  // ----
  always #12.5 core_clk = ~core_clk;
  adc_ctrl #(.SUM_W(16), .CONV_TICKS(20), .TIMEOUT_CYCLES(400)) dut (.core_clk(core_clk), .rstn(rstn),
    .spi_pins(spi_pins), .spi_out(spi_out), .sample_value(sample_value), .temp_value(temp_value),
    .afe_powered(afe_powered), .temp_sensor_select(temp_sensor_select), .afe_config(afe_config),
    .result_ready(result_ready));
  spi_host host (.pins(spi_pins), .pin_out(spi_out));
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_rdy(input logic lvl, output int n);
    n = 0;
    while (result_ready !== lvl && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 5000)
    begin
      errors++;
      end_sim();
    end
  endtask : wait_rdy
  task automatic t_reset();
    check("pin enable", 0, spi_out.data_out_ready_n_oe);
    check("config", CFG_RESET, afe_config);
    check("powered", 0, afe_powered);
    host.xfer(32, 32'h0, 1'b0, rd);
    check("ready pin", 1, host.rdy);
    check("first read", 32'h0000_058B, rd);
    $display("test reset done");
  endtask : t_reset
  task automatic t_single();
    logic [15:0] cfg [5] = '{16'h858B, 16'h858B, 16'h858B, 16'h858B, 16'h859B};
    logic [15:0] smp [5] = '{16'h0123, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
    logic [15:0] exp [5] = '{16'h1230, 16'h7FF0, 16'h8000, 16'hFFF0, 16'hF380};
    logic [15:0] prev = 16'h0000;
    int n;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      sample_value <= smp[i];
      host.xfer(32, {cfg[i], cfg[i]}, 1'b0, rd);
      check("readback", {prev, cfg[i] & 16'h7FFF}, rd);
      check("temp select", cfg[i][4], temp_sensor_select);
      wait_rdy(1'b1, n);
      repeat (2) @(posedge core_clk);
      check("asleep", 0, afe_powered);
      host.xfer(16, 32'h0, 1'b0, rd);
      check("ready low", 0, host.rdy);
      check("result", exp[i], rd[15:0]);
      repeat (900) @(posedge core_clk);
      check("one shot", 0, result_ready);
      prev = exp[i];
    end
    $display("test single done");
  endtask : t_single
  task automatic t_cont();
    int a;
    int b;
    @(posedge core_clk);
    sample_value <= 16'h0045;
    host.xfer(16, 32'h048B_0000, 1'b0, rd);
    wait_rdy(1'b1, a);
    wait_rdy(1'b0, a);
    wait_rdy(1'b1, b);
    check("powered", 1, afe_powered);
    check("early clear", 1, b >= 316 && b <= 324);
    check("period", 1, a + b >= 796 && a + b <= 804);
    sample_value <= 16'h0067;
    repeat (700) @(posedge core_clk);
    host.xfer(32, 32'h0, 1'b0, rd);
    check("snapshot", 32'h0450_048B, rd);
    check("new pending", 1, result_ready);
    host.xfer(16, 32'h058B_0000, 1'b0, rd);
    repeat (900) @(posedge core_clk);
    check("back to single", 0, afe_powered);
    $display("test continuous done");
  endtask : t_cont
  task automatic t_timeout();
    host.xfer(5, 32'hFFFF_FFFF, 1'b1, rd);
    repeat (450) @(posedge core_clk);
    host.xfer(32, 32'h0, 1'b1, rd);
    check("after timeout", 32'h0670_058B, rd);
    host.xfer(32, 32'hFFFF_FFFF, 1'b0, rd);
    check("select tied low", 32'h0670_058B, rd);
    check("no write", 16'h058B, afe_config);
    $display("test timeout done");
  endtask : t_timeout
  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_single();
    t_cont();
    t_timeout();
    end_sim();
  end
endmodule : adc_ctrl_test
